// *** rtl/cch_conn_ctrl.v ***
`timescale 1ns/1ps
`default_nettype none
`include "cch_defs.vh"

// Summary of operation
// - Terminal add: request, setup, acknowledgement.
// - Resend add request on retry timer expiry.
// - Retry length loaded on every initialization load with a nonzero length.
// - Resend acknowledgement on each duplicate setup during ack wait.
// - Identifier valid after the ack wait expires.
// - Discard duplicate setups for same transaction.
// - No uplink data before ack wait expires.
// - Base station add is setup then acknowledgement.
// - Change mirrors add; identifier never changes.
// - Reject direction reversal or unidirectional widening.
// - Delete only on upper-layer primitive, two-way.
// - Initiator retries delete request on expiry.
// - Both sides wait out delete ack timer.
// - Deleted identifier freed for reuse.
// - Change and delete retry one unit, ack wait eight units.
// - Terminal transaction identifiers in lower half.
module cch_conn_ctrl #(
	parameter TICK_CYC = `CCH_TICK_CYC,
	parameter TMR_W    = 20
) (
	input  wire                    i_clk_sys,
	input  wire                    i_rst,
	input  wire                    i_init_load,
	input  wire [`CCH_GRAN_W-1:0]  i_init_retry_len,
	input  wire                    i_gran_valid,
	input  wire [`CCH_GRAN_W-1:0]  i_gran,
	input  wire                    i_req_valid,
	output wire                    o_req_ready,
	input  wire [1:0]              i_req_kind,
	input  wire [`CCH_CID_W-1:0]   i_req_cid,
	input  wire [`CCH_DIR_W-1:0]   i_req_dir,
	input  wire [`CCH_DIR_W-1:0]   i_req_old_dir,
	input  wire                    i_rx_valid,
	input  wire [2:0]              i_rx_kind,
	input  wire [`CCH_TID_W-1:0]   i_rx_tid,
	input  wire [`CCH_CID_W-1:0]   i_rx_cid,
	input  wire                    i_rx_reject,
	output reg                     o_tx_valid,
	output reg  [2:0]              o_tx_kind,
	output reg  [`CCH_TID_W-1:0]   o_tx_tid,
	output reg  [`CCH_CID_W-1:0]   o_tx_cid,
	output reg                     o_done,
	output reg                     o_reject,
	output reg                     o_cid_valid,
	output reg  [`CCH_CID_W-1:0]   o_cid,
	output reg                     o_cid_freed,
	output reg                     o_busy
);

	// --------------------------------------------------------------
	// States
	// --------------------------------------------------------------
	localparam ST_IDLE    = 3'h0;
	localparam ST_WSETUP  = 3'h1;
	localparam ST_ACKWAIT = 3'h2;
	localparam ST_WDELACK = 3'h3;
	localparam ST_DELWAIT = 3'h4;

	function chg_ok;
		input [`CCH_DIR_W-1:0] old_d;
		input [`CCH_DIR_W-1:0] new_d;
		begin
			if (old_d == `CCH_DIR_UP || old_d == `CCH_DIR_DOWN)
				chg_ok = (new_d == old_d);
			else
				chg_ok = (new_d == `CCH_DIR_BI_SYM) || (new_d == `CCH_DIR_BI_ASYM);
		end
	endfunction

	function [TMR_W-1:0] units;
		input [`CCH_GRAN_W-1:0] g;
		input integer           n;
		begin
			units = {{(TMR_W-`CCH_GRAN_W){1'b0}}, g} * n[TMR_W-1:0];
		end
	endfunction

	reg [2:0]              state;
	reg [`CCH_TID_W-1:0]   tid;
	reg [`CCH_TID_W-2:0]   tid_seq;
	reg [`CCH_CID_W-1:0]   cid;
	reg                    is_change;
	reg [`CCH_GRAN_W-1:0]  gran;
	reg [`CCH_GRAN_W-1:0]  retry_len;
	reg [15:0]             tick_cnt;
	reg                    tick;

	localparam [31:0] TICK_LAST = TICK_CYC - 1;

	// --------------------------------------------------------------
	// Common tick
	// --------------------------------------------------------------
	always @(posedge i_clk_sys) begin
		if (i_rst) begin
			tick_cnt <= 16'h0000;
			tick     <= 1'b0;
		end else if (tick_cnt == TICK_LAST[15:0]) begin
			tick_cnt <= 16'h0000;
			tick     <= 1'b1;
		end else begin
			tick_cnt <= tick_cnt + 16'h0001;
			tick     <= 1'b0;
		end
	end

	// --------------------------------------------------------------
	// Configuration
	// --------------------------------------------------------------
	always @(posedge i_clk_sys) begin
		if (i_rst) begin
			gran      <= 16'h0001;
			retry_len <= 16'h0001;
		end else begin
			if (i_gran_valid && i_gran != 16'h0000)
				gran <= i_gran;
			if (i_init_load && i_init_retry_len != 16'h0000)
				retry_len <= i_init_retry_len;
		end
	end

	// --------------------------------------------------------------
	// Timers
	// --------------------------------------------------------------
	wire match  = i_rx_valid && (i_rx_tid == tid);
	wire accept = i_req_valid && o_req_ready;
	wire rx_set = i_rx_valid && ((i_rx_kind == `CCH_MSG_ADD_SET) ||
		(i_rx_kind == `CCH_MSG_CHG_SET));
	wire rx_bs_set = rx_set && i_rx_tid[`CCH_TID_W-1];
	wire rx_delreq = i_rx_valid && (i_rx_kind == `CCH_MSG_DEL_REQ);

	reg  rt_load, rt_stop, aw_load, aw_stop;
	reg  [TMR_W-1:0] rt_len, aw_len;
	wire rt_run, rt_exp, aw_run, aw_exp;

	cch_guard_timer #(.W(TMR_W)) u_retry (
		.i_clk_sys (i_clk_sys),
		.i_rst     (i_rst),
		.i_tick    (tick),
		.i_load    (rt_load),
		.i_stop    (rt_stop),
		.i_len     (rt_len),
		.o_running (rt_run),
		.o_expire  (rt_exp)
	);

	cch_guard_timer #(.W(TMR_W)) u_ackwait (
		.i_clk_sys (i_clk_sys),
		.i_rst     (i_rst),
		.i_tick    (tick),
		.i_load    (aw_load),
		.i_stop    (aw_stop),
		.i_len     (aw_len),
		.o_running (aw_run),
		.o_expire  (aw_exp)
	);

	assign o_req_ready = (state == ST_IDLE) && !rx_bs_set && !rx_delreq;

	// --------------------------------------------------------------
	// Procedure engine
	// --------------------------------------------------------------
	always @* begin
		rt_load = 1'b0;
		rt_stop = 1'b0;
		aw_load = 1'b0;
		aw_stop = 1'b0;
		rt_len  = {{(TMR_W-`CCH_GRAN_W){1'b0}}, retry_len};
		aw_len  = units(gran, `CCH_MEDIUM_UNITS);
		case (state)
		ST_IDLE: begin
			if (rx_bs_set || rx_delreq)
				aw_load = 1'b1;
			else if (accept && i_req_kind != `CCH_REQ_DELETE && !(i_req_kind ==
				`CCH_REQ_CHANGE && !chg_ok(i_req_old_dir, i_req_dir))) begin
				rt_load = 1'b1;
				if (i_req_kind == `CCH_REQ_CHANGE)
					rt_len = units(gran, `CCH_SHORT_UNITS);
			end else if (accept && i_req_kind == `CCH_REQ_DELETE) begin
				rt_load = 1'b1;
				rt_len  = units(gran, `CCH_SHORT_UNITS);
			end
		end
		ST_WSETUP: begin
			if (match && rx_set) begin
				rt_stop = 1'b1;
				aw_load = 1'b1;
			end else if (rt_exp) begin
				rt_load = 1'b1;
				if (is_change)
					rt_len = units(gran, `CCH_SHORT_UNITS);
			end
		end
		ST_ACKWAIT: begin
			if (match && rx_set)
				aw_load = 1'b1;
		end
		ST_WDELACK: begin
			if (match && i_rx_kind == `CCH_MSG_DEL_ACK) begin
				rt_stop = 1'b1;
				aw_load = 1'b1;
			end else if (rt_exp) begin
				rt_load = 1'b1;
				rt_len  = units(gran, `CCH_SHORT_UNITS);
			end
		end
		ST_DELWAIT: begin
			if (match && rx_delreq)
				aw_load = 1'b1;
		end
		default: begin
			rt_stop = 1'b1;
			aw_stop = 1'b1;
		end
		endcase
	end

	always @(posedge i_clk_sys) begin
		if (i_rst) begin
			state       <= ST_IDLE;
			tid         <= {`CCH_TID_W{1'b0}};
			tid_seq     <= {(`CCH_TID_W-1){1'b0}};
			cid         <= {`CCH_CID_W{1'b0}};
			is_change   <= 1'b0;
			o_tx_valid  <= 1'b0;
			o_tx_kind   <= 3'h0;
			o_tx_tid    <= {`CCH_TID_W{1'b0}};
			o_tx_cid    <= {`CCH_CID_W{1'b0}};
			o_done      <= 1'b0;
			o_reject    <= 1'b0;
			o_cid_valid <= 1'b0;
			o_cid       <= {`CCH_CID_W{1'b0}};
			o_cid_freed <= 1'b0;
			o_busy      <= 1'b0;
		end else begin
			o_tx_valid  <= 1'b0;
			o_done      <= 1'b0;
			o_reject    <= 1'b0;
			o_cid_freed <= 1'b0;
			o_busy      <= (state != ST_IDLE);
			case (state)
			ST_IDLE: begin
				if (rx_bs_set) begin
					// Base-station initiated add or change.
					tid        <= i_rx_tid;
					cid        <= i_rx_cid;
					is_change  <= (i_rx_kind == `CCH_MSG_CHG_SET);
					o_tx_valid <= 1'b1;
					o_tx_kind  <= (i_rx_kind == `CCH_MSG_CHG_SET) ?
						`CCH_MSG_CHG_ACK : `CCH_MSG_ADD_ACK;
					o_tx_tid   <= i_rx_tid;
					o_tx_cid   <= i_rx_cid;
					if (i_rx_kind == `CCH_MSG_ADD_SET)
						o_cid_valid <= 1'b0;
					state      <= ST_ACKWAIT;
				end else if (rx_delreq) begin
					tid         <= i_rx_tid;
					cid         <= i_rx_cid;
					o_tx_valid  <= 1'b1;
					o_tx_kind   <= `CCH_MSG_DEL_ACK;
					o_tx_tid    <= i_rx_tid;
					o_tx_cid    <= i_rx_cid;
					o_cid_valid <= 1'b0;
					state       <= ST_DELWAIT;
				end else if (accept) begin
					if (i_req_kind == `CCH_REQ_CHANGE &&
						!chg_ok(i_req_old_dir, i_req_dir)) begin
						o_reject <= 1'b1;
					end else begin
						tid        <= {1'b0, tid_seq};
						tid_seq    <= tid_seq + 16'h0001;
						cid        <= i_req_cid;
						is_change  <= (i_req_kind == `CCH_REQ_CHANGE);
						o_tx_valid <= 1'b1;
						o_tx_tid   <= {1'b0, tid_seq};
						o_tx_cid   <= i_req_cid;
						if (i_req_kind == `CCH_REQ_DELETE) begin
							o_tx_kind   <= `CCH_MSG_DEL_REQ;
							o_cid_valid <= 1'b0;
							state       <= ST_WDELACK;
						end else begin
							o_tx_kind <= (i_req_kind == `CCH_REQ_CHANGE) ?
								`CCH_MSG_CHG_REQ : `CCH_MSG_ADD_REQ;
							state     <= ST_WSETUP;
						end
					end
				end
			end
			ST_WSETUP: begin
				if (match && rx_set) begin
					o_tx_valid <= 1'b1;
					o_tx_kind  <= is_change ? `CCH_MSG_CHG_ACK :
						`CCH_MSG_ADD_ACK;
					o_tx_tid   <= tid;
					o_tx_cid   <= is_change ? cid : i_rx_cid;
					if (!is_change)
						cid <= i_rx_cid;
					if (i_rx_reject) begin
						o_reject <= 1'b1;
						state    <= ST_IDLE;
					end else begin
						o_cid_valid <= is_change ? o_cid_valid : 1'b0;
						state       <= ST_ACKWAIT;
					end
				end else if (rt_exp) begin
					o_tx_valid <= 1'b1;
					o_tx_kind  <= is_change ? `CCH_MSG_CHG_REQ :
						`CCH_MSG_ADD_REQ;
					o_tx_tid   <= tid;
					o_tx_cid   <= cid;
				end
			end
			ST_ACKWAIT: begin
				if (match && rx_set) begin
					// Duplicate setup: reacknowledge and restart the ack wait, keep no other new state.
					o_tx_valid <= 1'b1;
					o_tx_kind  <= is_change ? `CCH_MSG_CHG_ACK :
						`CCH_MSG_ADD_ACK;
					o_tx_tid   <= tid;
					o_tx_cid   <= cid;
				end else if (aw_exp) begin
					o_cid_valid <= 1'b1;
					o_cid       <= cid;
					o_done      <= 1'b1;
					state       <= ST_IDLE;
				end
			end
			ST_WDELACK: begin
				if (match && i_rx_kind == `CCH_MSG_DEL_ACK) begin
					state <= ST_DELWAIT;
				end else if (rt_exp) begin
					o_tx_valid <= 1'b1;
					o_tx_kind  <= `CCH_MSG_DEL_REQ;
					o_tx_tid   <= tid;
					o_tx_cid   <= cid;
				end
			end
			ST_DELWAIT: begin
				if (match && rx_delreq) begin
					o_tx_valid <= 1'b1;
					o_tx_kind  <= `CCH_MSG_DEL_ACK;
					o_tx_tid   <= tid;
					o_tx_cid   <= cid;
				end else if (aw_exp) begin
					o_cid_freed <= 1'b1;
					o_cid       <= cid;
					o_done      <= 1'b1;
					state       <= ST_IDLE;
				end
			end
			default: state <= ST_IDLE;
			endcase
		end
	end

endmodule

`default_nettype wire

// *** rtl/cch_defs.vh ***
`ifndef CCH_DEFS_VH
`define CCH_DEFS_VH

// Identifier, granularity and direction field widths.
`define CCH_TID_W        17
`define CCH_CID_W        16
`define CCH_GRAN_W       16
`define CCH_DIR_W        2

// Flow direction choice codes.
`define CCH_DIR_UP       2'h0
`define CCH_DIR_DOWN     2'h1
`define CCH_DIR_BI_SYM   2'h2
`define CCH_DIR_BI_ASYM  2'h3

// Request kinds on the user side.
`define CCH_REQ_ADD      2'h0
`define CCH_REQ_CHANGE   2'h1
`define CCH_REQ_DELETE   2'h2

// Message kinds on the link side.
`define CCH_MSG_ADD_REQ  3'h0
`define CCH_MSG_ADD_SET  3'h1
`define CCH_MSG_ADD_ACK  3'h2
`define CCH_MSG_CHG_REQ  3'h3
`define CCH_MSG_CHG_SET  3'h4
`define CCH_MSG_CHG_ACK  3'h5
`define CCH_MSG_DEL_REQ  3'h6
`define CCH_MSG_DEL_ACK  3'h7

// Timer lengths in granularity units.
`define CCH_SHORT_UNITS  1
`define CCH_MEDIUM_UNITS 8

// Clock rate and default tick period.
`define CCH_CLK_HZ       20000000
`define CCH_TICK_US      1
`define CCH_TICK_CYC     ((`CCH_CLK_HZ / 1000000) * `CCH_TICK_US)

`endif

// *** rtl/cch_guard_timer.v ***
`timescale 1ns/1ps
`default_nettype none

// Down-counting guard timer; a load always restarts from the full length.
module cch_guard_timer #(
	parameter W = 20
) (
	input  wire         i_clk_sys,
	input  wire         i_rst,
	input  wire         i_tick,
	input  wire         i_load,
	input  wire         i_stop,
	input  wire [W-1:0] i_len,
	output reg          o_running,
	output wire         o_expire
);

	reg [W-1:0] count;

	// Expiry does not look at load or stop, so that the caller may decide
	// a reload from it without closing a combinational loop.
	assign o_expire = o_running && i_tick &&
		(count == {{(W-1){1'b0}}, 1'b1});

	always @(posedge i_clk_sys) begin
		if (i_rst) begin
			count     <= {W{1'b0}};
			o_running <= 1'b0;
		end else if (i_load) begin
			count     <= i_len;
			o_running <= 1'b1;
		end else if (i_stop) begin
			o_running <= 1'b0;
		end else if (o_running && i_tick) begin
			count <= count - {{(W-1){1'b0}}, 1'b1};
			if (count == {{(W-1){1'b0}}, 1'b1})
				o_running <= 1'b0;
		end
	end

endmodule

`default_nettype wire

// *** verification/cch_bs_model.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "cch_defs.vh"
module cch_bs_model #(
	parameter logic [15:0] CID_P = 16'h0123
) (
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst,
	input  wire logic        i_tx_valid,
	input  wire logic [2:0]  i_tx_kind,
	input  wire logic [16:0] i_tx_tid,
	input  wire logic [15:0] i_tx_cid,
	input  wire logic        i_lose,
	input  wire logic        i_inj,
	input  wire logic [2:0]  i_inj_kind,
	input  wire logic [16:0] i_inj_tid,
	output logic             o_rx_valid = 1'b0,
	output logic [2:0]       o_rx_kind = 3'h0,
	output logic [16:0]      o_rx_tid = 17'h0,
	output logic [15:0]      o_rx_cid = 16'h0,
	output logic             o_rx_reject = 1'b0
);
	logic [1:0]  pend = 2'h0;
	logic        sopen = 1'b0;
	logic [3:0]  sret = 4'h0;
	logic [2:0]  k;
	logic [16:0] t;
	logic [15:0] c;
	wire answer = (i_tx_kind == `CCH_MSG_ADD_REQ) ||
		(i_tx_kind == `CCH_MSG_CHG_REQ) || (i_tx_kind == `CCH_MSG_DEL_REQ);
	// Acknowledgement of the setup that is still open.
	wire ack_in = i_tx_valid && (i_tx_tid == t) &&
		((i_tx_kind == `CCH_MSG_ADD_ACK) || (i_tx_kind == `CCH_MSG_CHG_ACK));
	// Idle tid and cid fields flip every cycle so stale values are never trusted.
	always @(posedge i_clk_sys) begin
		o_rx_valid <= 1'b0;
		o_rx_tid <= ~o_rx_tid;
		o_rx_cid <= ~o_rx_cid;
		if (sret != 4'h0)
			sret <= sret - 4'h1;
		if (i_rst) begin
			pend <= 2'h0;
			sopen <= 1'b0;
		end else if (i_inj) begin
			o_rx_valid <= 1'b1;
			o_rx_kind <= i_inj_kind;
			o_rx_tid <= i_inj_tid;
			o_rx_cid <= CID_P;
		end else if (pend == 2'h1) begin
			o_rx_valid <= 1'b1;
			o_rx_kind <= k;
			o_rx_tid <= t;
			o_rx_cid <= c;
			pend <= 2'h0;
			sopen <= (k == `CCH_MSG_ADD_SET) || (k == `CCH_MSG_CHG_SET);
			sret <= 4'ha;
		end else if (pend != 2'h0) begin
			pend <= pend - 2'h1;
		end else if (sopen && ack_in) begin
			sopen <= 1'b0;
		end else if (sopen && sret == 4'h0) begin
			o_rx_valid <= 1'b1;
			o_rx_kind <= k;
			o_rx_tid <= t;
			o_rx_cid <= c;
			sret <= 4'ha;
		end else if (i_tx_valid && answer && !i_lose) begin
			pend <= 2'h3;
			k <= i_tx_kind + 3'h1;
			t <= i_tx_tid;
			c <= (i_tx_kind == `CCH_MSG_ADD_REQ) ? CID_P : i_tx_cid;
		end
	end
endmodule
`default_nettype wire

// *** verification/cch_conn_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "cch_defs.vh"
module cch_conn_chk #(
	parameter TICK_CYC = 2
) (
	input wire logic        i_clk_sys,
	input wire logic        i_rst,
	input wire logic        i_req_valid,
	input wire logic        o_req_ready,
	input wire logic [1:0]  i_req_kind,
	input wire logic [15:0] i_req_cid,
	input wire logic [1:0]  i_req_dir,
	input wire logic [1:0]  i_req_old_dir,
	input wire logic        i_rx_valid,
	input wire logic [2:0]  i_rx_kind,
	input wire logic        o_tx_valid,
	input wire logic [2:0]  o_tx_kind,
	input wire logic [16:0] o_tx_tid,
	input wire logic [15:0] o_tx_cid,
	input wire logic        o_reject,
	input wire logic        o_cid_valid,
	input wire logic        o_cid_freed
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);
	logic [7:0] wait_cnt;
	wire take = i_req_valid && o_req_ready;
	wire bad = (i_req_old_dir < 2'h2) && (i_req_dir != i_req_old_dir);
	wire ack_tx = o_tx_valid && (o_tx_kind == `CCH_MSG_ADD_ACK);
	// Cycles since the last add acknowledgement left the block.
	always @(posedge i_clk_sys)
		if (i_rst || ack_tx)
			wait_cnt <= 8'h0;
		else if (wait_cnt != 8'hff)
			wait_cnt <= wait_cnt + 8'h1;
	a_add_req_sent: assert property (
		take && i_req_kind == `CCH_REQ_ADD |=> o_tx_valid &&
		o_tx_kind == `CCH_MSG_ADD_REQ && !o_tx_tid[16])
		else $error("add request not sent");
	a_del_req_sent: assert property (
		take && i_req_kind == `CCH_REQ_DELETE |=> o_tx_valid &&
		o_tx_kind == `CCH_MSG_DEL_REQ && o_tx_cid == $past(i_req_cid))
		else $error("delete request not sent");
	a_chg_bad_reject: assert property (
		take && i_req_kind == `CCH_REQ_CHANGE && bad |=>
		o_reject && !o_tx_valid)
		else $error("bad change not refused");
	a_chg_cid_kept: assert property (
		take && i_req_kind == `CCH_REQ_CHANGE && !bad |=> o_tx_valid &&
		o_tx_kind == `CCH_MSG_CHG_REQ && o_tx_cid == $past(i_req_cid))
		else $error("change request wrong");
	a_retry_gap: assert property (
		o_tx_valid && o_tx_kind == `CCH_MSG_ADD_REQ |=> !o_tx_valid [*2])
		else $error("add request resent too soon");
	a_ack_wait_min: assert property (
		$rose(o_cid_valid) |-> wait_cnt >= 7 * TICK_CYC)
		else $error("identifier valid before ack wait");
	a_freed_drops: assert property (
		o_cid_freed |=> !o_cid_valid)
		else $error("freed identifier still valid");
	a_ready_idle: assert property (
		i_rx_valid && i_rx_kind == `CCH_MSG_DEL_REQ |-> !o_req_ready)
		else $error("ready during far delete");
	c_add_done: cover property ($rose(o_cid_valid));
	c_reject: cover property (o_reject);
	c_freed: cover property (o_cid_freed);
endmodule
bind cch_conn_ctrl cch_conn_chk #(.TICK_CYC(TICK_CYC)) i_chk (
	.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_req_valid(i_req_valid),
	.o_req_ready(o_req_ready), .i_req_kind(i_req_kind),
	.i_req_cid(i_req_cid), .i_req_dir(i_req_dir),
	.i_req_old_dir(i_req_old_dir), .i_rx_valid(i_rx_valid),
	.i_rx_kind(i_rx_kind), .o_tx_valid(o_tx_valid), .o_tx_kind(o_tx_kind),
	.o_tx_tid(o_tx_tid), .o_tx_cid(o_tx_cid), .o_reject(o_reject),
	.o_cid_valid(o_cid_valid), .o_cid_freed(o_cid_freed));
`default_nettype wire

// *** verification/test_connection_control_handshake.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "cch_defs.vh"
module test_connection_control_handshake;
	logic        clk = 1'b0, rst = 1'b1, init_ld = 1'b0, gran_v = 1'b0;
	logic        req_v = 1'b0, lose = 1'b0, inj = 1'b0;
	localparam int TK = 2;
	logic [15:0] init_len = 16'h4, gran = 16'h1, req_cid = 16'h0;
	logic [1:0]  req_kind = 2'h0, req_dir = 2'h0, old_dir = 2'h0;
	logic [2:0]  inj_kind = 3'h0;
	logic [16:0] inj_tid = 17'h0, tid = 17'h0, tx_n = 17'h0;
	wire logic rdy, rx_v, rx_rj, tx_v, done, rej, cv, freed, busy;
	wire logic [2:0]  rx_k, tx_k;
	wire logic [16:0] rx_t, tx_t;
	wire logic [15:0] rx_c, tx_c, cid;
	int err_total = 0, cmp_count = 0, cyc = 0;
	always #25 clk = ~clk;
	cch_conn_ctrl #(.TICK_CYC(TK)) i_dut (.i_clk_sys(clk), .i_rst(rst),
		.i_init_load(init_ld), .i_init_retry_len(init_len),
		.i_gran_valid(gran_v), .i_gran(gran), .i_req_valid(req_v),
		.o_req_ready(rdy), .i_req_kind(req_kind), .i_req_cid(req_cid),
		.i_req_dir(req_dir), .i_req_old_dir(old_dir), .i_rx_valid(rx_v),
		.i_rx_kind(rx_k), .i_rx_tid(rx_t), .i_rx_cid(rx_c),
		.i_rx_reject(rx_rj), .o_tx_valid(tx_v), .o_tx_kind(tx_k),
		.o_tx_tid(tx_t), .o_tx_cid(tx_c), .o_done(done), .o_reject(rej),
		.o_cid_valid(cv), .o_cid(cid), .o_cid_freed(freed), .o_busy(busy));
	cch_bs_model i_bs (.i_clk_sys(clk), .i_rst(rst), .i_tx_valid(tx_v),
		.i_tx_kind(tx_k), .i_tx_tid(tx_t), .i_tx_cid(tx_c), .i_lose(lose),
		.i_inj(inj), .i_inj_kind(inj_kind), .i_inj_tid(inj_tid),
		.o_rx_valid(rx_v), .o_rx_kind(rx_k), .o_rx_tid(rx_t),
		.o_rx_cid(rx_c), .o_rx_reject(rx_rj));
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (tx_v)
			tx_n <= tx_n + 17'h1;
		if (cyc == 20000) begin
			err_total++;
			results();
		end
	end
	task automatic results();
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [16:0] e, g);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic req(input logic [1:0] k, d, od);
		@(posedge clk);
		req_v <= 1'b1;
		req_kind <= k;
		req_cid <= 16'h0123;
		req_dir <= d;
		old_dir <= od;
		do @(negedge clk); while (rdy !== 1'b1);
		@(posedge clk);
		req_v <= 1'b0;
	endtask
	task automatic send(input logic [2:0] k, input logic [16:0] t);
		@(posedge clk);
		inj <= 1'b1;
		inj_kind <= k;
		inj_tid <= t;
		@(posedge clk);
		inj <= 1'b0;
	endtask
	task automatic wait_tx(input logic [2:0] k, output int n);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (!(tx_v === 1'b1 && tx_k === k) && n < 400);
		chk("tx_seen", 17'h1, {16'h0, tx_v});
	endtask
	task automatic wait_done(output int n);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while ((done | rej | freed) !== 1'b1 && n < 400);
		chk("end_seen", 17'h1, {16'h0, done | rej | freed});
	endtask
	task automatic t_add(input logic [15:0] g, input logic l);
		int n;
		logic ok;
		@(posedge clk);
		gran <= g;
		gran_v <= 1'b1;
		lose <= l;
		@(posedge clk);
		gran_v <= 1'b0;
		req(`CCH_REQ_ADD, 2'h0, 2'h0);
		wait_tx(`CCH_MSG_ADD_REQ, n);
		tid = tx_t;
		chk("tid_half", 17'h0, {16'h0, tid[16]});
		@(posedge clk);
		lose <= 1'b0;
		if (l) begin
			wait_tx(`CCH_MSG_ADD_REQ, n);
			ok = n > TK * (init_len - 1) && n <= TK * init_len;
			chk("retry_time", 17'h1, {16'h0, ok});
			chk("retry_tid", tid, tx_t);
		end
		wait_tx(`CCH_MSG_ADD_ACK, n);
		chk("ack_tid", tid, tx_t);
		chk("busy", 17'h1, {16'h0, busy});
		wait_done(n);
		chk("ack_wait", 17'h1, {16'h0, n + 2 >= 16 * g && n <= 16 * g + 2});
		chk("done", 17'h1, {16'h0, done});
		chk("cid", 17'h0123, {1'b0, cid});
		chk("cid_valid", 17'h1, {16'h0, cv});
	endtask
	task automatic t_stray();
		logic [16:0] n0;
		n0 = tx_n;
		send(`CCH_MSG_ADD_SET, tid);
		send(`CCH_MSG_CHG_SET, tid ^ 17'h5);
		repeat (10) @(posedge clk);
		chk("stray_tx", n0, tx_n);
	endtask
	task automatic t_change();
		logic [1:0] od [5] = '{2'h2, 2'h3, 2'h0, 2'h0, 2'h1};
		logic [1:0] nd [5] = '{2'h3, 2'h2, 2'h1, 2'h2, 2'h0};
		logic [16:0] n0;
		int n;
		// A granularity above the setup latency keeps the change retry quiet.
		@(posedge clk);
		gran <= 16'h4;
		gran_v <= 1'b1;
		@(posedge clk);
		gran_v <= 1'b0;
		for (int i = 0; i < 5; i++) begin
			n0 = tx_n;
			req(`CCH_REQ_CHANGE, nd[i], od[i]);
			wait_done(n);
			chk("chg_reject", {16'h0, i > 1}, {16'h0, rej});
			chk("chg_tx", n0 + ((i > 1) ? 17'h0 : 17'h2), tx_n);
			if (i < 2)
				chk("chg_cid", 17'h0123, {1'b0, tx_c});
		end
	endtask
	task automatic t_delete();
		int n;
		logic ok;
		@(posedge clk);
		lose <= 1'b1;
		req(`CCH_REQ_DELETE, 2'h0, 2'h0);
		wait_tx(`CCH_MSG_DEL_REQ, n);
		chk("del_cid", 17'h0123, {1'b0, tx_c});
		@(posedge clk);
		lose <= 1'b0;
		wait_tx(`CCH_MSG_DEL_REQ, n);
		ok = n > TK * (gran - 1) && n <= TK * gran;
		chk("del_retry", 17'h1, {16'h0, ok});
		wait_done(n);
		chk("del_wait", 17'h1, {16'h0, n + 8 >= 16 * gran});
		chk("del_freed", 17'h1, {16'h0, freed});
	endtask
	task automatic t_bs_del();
		int n;
		send(`CCH_MSG_DEL_REQ, 17'h10005);
		wait_tx(`CCH_MSG_DEL_ACK, n);
		chk("bs_ack_tid", 17'h10005, tx_t);
		send(`CCH_MSG_DEL_REQ, 17'h10005);
		wait_tx(`CCH_MSG_DEL_ACK, n);
		chk("bs_ack_again", 17'h1, {16'h0, n <= 2});
		wait_done(n);
		chk("bs_freed", 17'h1, {16'h0, freed});
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		init_ld <= 1'b1;
		@(posedge clk);
		init_ld <= 1'b0;
		t_add(16'h1, 1'b1);
		t_stray();
		t_change();
		t_add(16'h2, 1'b0);
		t_delete();
		t_add(16'h1, 1'b0);
		t_bs_del();
		results();
	end
endmodule
`default_nettype wire
